// ### logic/ebr_pkg.sv
/*
  Package for the external bus release interface: bus timing counts,
  pin-mode reset values and field layouts.
  Assumes a 100 MHz core clock; no registers are reached by software.
*/
package ebr_pkg;
  // ****************************************
  // Clocking and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_DIV = 4;
  localparam int OSC_HALF = OSC_DIV / 2;
  localparam int ALE_NS = 10;
  localparam int ALE_CYC = (ALE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_NS = 20;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // ****************************************
  // Widths and areas
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int NUM_SEL = 3;
  localparam int SEL_PULLUP_IDX = 2;
  localparam logic [NUM_SEL-1:0] SEL_OFF = 3'h7;
  // Upper lane modes
  localparam logic UPPER_AD = 1'h0;
  localparam logic UPPER_ADDR = 1'h1;
  // Third port modes
  localparam logic PORT2_LOW = 1'h0;
  localparam logic PORT2_HIGH = 1'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_STROBE,
    ST_END,
    ST_REL_WAIT,
    ST_RELEASED
  } ebr_state_e;
endpackage

// ### logic/ebr_area_decode.sv
/*
  One address area comparator: a registered hit flag for one select.
  Assumes base and mask come from stable configuration inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module ebr_area_decode
  import ebr_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [AW-1:0] base_i,
  input wire logic [AW-1:0] mask_i,
  input wire logic enable_i,
  output logic hit_o
);
  wire logic match;
  assign match = enable_i && (((addr_i ^ base_i) & mask_i) == '0);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hit_o <= 1'b0;
    end else begin
      hit_o <= match;
    end
  end
endmodule
`default_nettype wire

// ### logic/ebr_bus_if.sv
/*
  External bus release interface: multiplexed address/data bus engine,
  area selects with DRAM column strobes, row strobe, bus release
  handshake and divided clock output.
  Assumes cpu request signals are on clk_i; pins from outside pass
  two flip-flops; bidirectional pins are split into in/out/enable.
*/
//
// Contract
// - Direction output high for read or dummy cycles, low for writes.
// - On request float bus pins, then assert bus grant.
// - While released, outside accesses to internal memory are ignored.
// - Area select low when address lies in its area, high otherwise.
// - In DRAM mode each select pin outputs a column strobe instead.
// - Row strobe pin drives row strobe for DRAM accesses.
// - Third select pin gets pull-up, not pull-down, while released.
// - Read strobe asserted while reading external memory.
// - Low write strobe asserted for lower byte lane writes.
// - High write strobe asserted for upper byte lane writes.
// - Lower lane muxes address/data 0-7; upper lane is AD or address.
// - Third port gives address 0-7 or 16-23 per configuration.
// - Clock output is oscillator over four, held high during reset.
// - Software can disconnect pull resistors from all bus pins.
// - After reset shared pins act as general port pins; code: only the AD lines, via port_out_i/port_oe_i, while bus_enable_i is low.
`timescale 1ns/1ps
`default_nettype none
module ebr_bus_if
  import ebr_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W,
  parameter int NS = NUM_SEL
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Cpu side
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_dummy_i,
  input wire logic [1:0] req_lanes_i,
  input wire logic [AW-1:0] req_addr_i,
  input wire logic [DW-1:0] req_wdata_i,
  output logic req_done_o,
  output logic [DW-1:0] req_rdata_o,
  // Configuration
  input wire logic bus_enable_i,
  input wire logic upper_mode_i,
  input wire logic port2_mode_i,
  input wire logic [NS-1:0] dram_mode_i,
  input wire logic [NS-1:0] sel_enable_i,
  input wire logic [NS*AW-1:0] sel_base_i,
  input wire logic [NS*AW-1:0] sel_mask_i,
  input wire logic pull_enable_i,
  input wire logic [DW-1:0] port_out_i,
  input wire logic [DW-1:0] port_oe_i,
  input wire logic ext_internal_access_i,
  output logic ext_internal_ack_o,
  // Pins
  input wire logic [DW-1:0] mux_addr_data_lines_i,
  output logic [DW-1:0] mux_addr_data_lines_o,
  output logic [DW-1:0] mux_addr_data_lines_oe_o,
  output logic [7:0] address_lines_o,
  output logic address_lines_oe_o,
  output logic read_strobe_n_o,
  output logic low_byte_write_strobe_n_o,
  output logic high_byte_write_strobe_n_o,
  output logic read_write_o,
  output logic row_strobe_n_o,
  output logic [NS-1:0] area_select_n_o,
  output logic strobe_oe_o,
  output logic addr_latch_en_o,
  input wire logic wait_n_i,
  input wire logic bus_request_n_i,
  output logic bus_grant_n_o,
  output logic clk_out_o,
  output logic [NS-1:0] sel_pull_up_o,
  output logic [NS-1:0] sel_pull_down_o,
  output logic bus_pull_en_o
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic wait_s1_r, wait_s2_r, bus_request_n_s1_r, bus_request_n_s2_r;
  logic [DW-1:0] din_s1_r, din_s2_r;
  // Active-low pins idle high, so their chains reset high
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_s1_r <= 1'b1;
      wait_s2_r <= 1'b1;
      bus_request_n_s1_r <= 1'b1;
      bus_request_n_s2_r <= 1'b1;
      din_s1_r <= '0;
      din_s2_r <= '0;
    end else begin
      wait_s1_r <= wait_n_i;
      wait_s2_r <= wait_s1_r;
      bus_request_n_s1_r <= bus_request_n_i;
      bus_request_n_s2_r <= bus_request_n_s1_r;
      din_s1_r <= mux_addr_data_lines_i;
      din_s2_r <= din_s1_r;
    end
  end

  // ****************************************
  // Clock output divider
  // ****************************************
  // Two toggles per four clocks give a quarter-rate square wave
  logic [1:0] div_r;
  logic clk_out_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= '0;
      clk_out_r <= 1'b1;
    end else begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'(OSC_HALF - 1) || div_r == 2'(OSC_DIV - 1)) begin
        clk_out_r <= ~clk_out_r;
      end
    end
  end
  assign clk_out_o = clk_out_r;

  // ****************************************
  // Area decoders
  // ****************************************
  ebr_state_e st_r, st_nxt;
  logic [AW-1:0] addr_r;
  // Decode the incoming address while idle so selects are right at once
  wire logic [AW-1:0] dec_addr = (st_r == ST_IDLE) ? req_addr_i : addr_r;
  wire logic [NS-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sel
      ebr_area_decode #(.AW(AW)) u_dec (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .addr_i(dec_addr),
        .base_i(sel_base_i[g*AW +: AW]),
        .mask_i(sel_mask_i[g*AW +: AW]),
        .enable_i(sel_enable_i[g]),
        .hit_o(hit[g])
      );
    end
  endgenerate

  // ****************************************
  // Bus cycle engine
  // ****************************************
  logic [CNT_W-1:0] cnt_r;
  logic write_r, dummy_r;
  logic [1:0] lanes_r;
  logic [DW-1:0] wdata_r;
  wire logic released = (st_r == ST_RELEASED);
  wire logic bus_request_n = !bus_request_n_s2_r;
  wire logic waiting = !wait_s2_r;
  wire logic cnt_done = (cnt_r == '0);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (bus_request_n && bus_enable_i) begin
          st_nxt = ST_REL_WAIT;
        end else if (req_i && bus_enable_i) begin
          st_nxt = ST_ADDR;
        end
      end
      ST_ADDR: if (cnt_done) st_nxt = ST_STROBE;
      ST_STROBE: if (cnt_done && !waiting) st_nxt = ST_END;
      ST_END: st_nxt = ST_IDLE;
      ST_REL_WAIT: st_nxt = bus_request_n ? ST_RELEASED : ST_IDLE;
      ST_RELEASED: if (!bus_request_n) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  wire logic start = (st_r == ST_IDLE) && (st_nxt == ST_ADDR);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      addr_r <= '0;
      write_r <= 1'b0;
      dummy_r <= 1'b0;
      lanes_r <= '0;
      wdata_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (start) begin
        cnt_r <= CNT_W'(ALE_CYC);
        addr_r <= req_addr_i;
        write_r <= req_write_i;
        dummy_r <= req_dummy_i;
        lanes_r <= req_lanes_i;
        wdata_r <= req_wdata_i;
      end else if (st_r == ST_ADDR && cnt_done) begin
        cnt_r <= CNT_W'(STROBE_CYC);
      end else if (!cnt_done) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // ****************************************
  // Pin drive decode
  // ****************************************
  wire logic in_addr = (st_r == ST_ADDR);
  wire logic in_strb = (st_r == ST_STROBE);
  wire logic active = in_addr || in_strb || (st_r == ST_END);
  wire logic is_read = !write_r && !dummy_r;
  wire logic bus_own = bus_enable_i && !released && (st_r != ST_REL_WAIT);
  wire logic rd_n = !(in_strb && is_read);
  wire logic wrl_n = !(in_strb && write_r && lanes_r[0]);
  wire logic wrh_n = !(in_strb && write_r && lanes_r[1]);
  wire logic rw = !(active && write_r);
  wire logic ras_n = !((in_strb || in_addr && !cnt_done) && |(hit & dram_mode_i));
  wire logic [NS-1:0] cs_n = ~(hit & ~dram_mode_i & {NS{active}});
  wire logic [NS-1:0] cas_n = ~(hit & dram_mode_i & {NS{in_strb}});
  wire logic [NS-1:0] sel_n = cs_n & cas_n;
  wire logic [7:0] lo_lane = (in_addr || !write_r) ? addr_r[7:0] : wdata_r[7:0];
  wire logic [7:0] hi_lane =
    (upper_mode_i == UPPER_ADDR || in_addr || !write_r) ? addr_r[15:8] : wdata_r[15:8];
  wire logic lo_oe = in_addr || (active && write_r);
  wire logic hi_oe = lo_oe || (upper_mode_i == UPPER_ADDR && active);
  wire logic [7:0] p2 = (port2_mode_i == PORT2_HIGH) ? addr_r[23:16] : addr_r[7:0];
  wire logic [DW-1:0] bus_dout = {hi_lane, lo_lane};
  wire logic [DW-1:0] bus_doe = {{8{hi_oe}}, {8{lo_oe}}};
  wire logic [DW-1:0] pins_dout = bus_enable_i ? bus_dout : port_out_i;
  wire logic [DW-1:0] pins_doe = bus_enable_i ? (bus_own ? bus_doe : '0) : port_oe_i;
  wire logic [NS-1:0] pu_idle = {NS{1'b1}} ^ (NS'(1) << SEL_PULLUP_IDX);
  wire logic [NS-1:0] pu = released ? SEL_OFF : pu_idle;

  // ****************************************
  // Latch pulse, read capture and grant
  // ****************************************
  // Pulse only while the address already stands on the lines
  wire logic ale_nxt = in_addr && !cnt_done;
  // Synced data lags two edges, so take it once the strobe has ended
  wire logic rdata_take = (st_r == ST_END) && is_read;
  // Grant follows the floated pins by one cycle
  wire logic grant_n_nxt = !released;

  // ****************************************
  // Pull resistors
  // ****************************************
  // Third select swaps its pull-down for a pull-up while released
  wire logic [NS-1:0] pull_up_nxt = pull_enable_i ? pu : '0;
  wire logic [NS-1:0] pull_dn_nxt = pull_enable_i ? ~pu : '0;

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mux_addr_data_lines_o <= '0;
      mux_addr_data_lines_oe_o <= '0;
      address_lines_o <= '0;
      address_lines_oe_o <= 1'b0;
      read_strobe_n_o <= 1'b1;
      low_byte_write_strobe_n_o <= 1'b1;
      high_byte_write_strobe_n_o <= 1'b1;
      read_write_o <= 1'b1;
      row_strobe_n_o <= 1'b1;
      area_select_n_o <= SEL_OFF;
      strobe_oe_o <= 1'b0;
      addr_latch_en_o <= 1'b0;
      bus_grant_n_o <= 1'b1;
      req_done_o <= 1'b0;
      req_rdata_o <= '0;
      ext_internal_ack_o <= 1'b0;
      sel_pull_up_o <= '0;
      sel_pull_down_o <= '0;
      bus_pull_en_o <= 1'b0;
    end else begin
      mux_addr_data_lines_o <= pins_dout;
      mux_addr_data_lines_oe_o <= pins_doe;
      address_lines_o <= p2;
      address_lines_oe_o <= bus_own;
      read_strobe_n_o <= rd_n;
      low_byte_write_strobe_n_o <= wrl_n;
      high_byte_write_strobe_n_o <= wrh_n;
      read_write_o <= rw;
      row_strobe_n_o <= ras_n;
      area_select_n_o <= sel_n;
      strobe_oe_o <= bus_own;
      addr_latch_en_o <= ale_nxt;
      bus_grant_n_o <= grant_n_nxt;
      req_done_o <= (st_r == ST_END);
      if (rdata_take) begin
        req_rdata_o <= din_s2_r;
      end
      ext_internal_ack_o <= 1'b0 && ext_internal_access_i;
      sel_pull_up_o <= pull_up_nxt;
      sel_pull_down_o <= pull_dn_nxt;
      bus_pull_en_o <= pull_enable_i;
    end
  end
endmodule
`default_nettype wire

// ### dv/ebr_bus_if_monitor.sv
/* Checker on the top ports of the bus interface.
   Assumes a bind into ebr_bus_if with its own widths. */
`timescale 1ns/1ps
`default_nettype none
module ebr_mon
  import ebr_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int NS = NUM_SEL
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pull_enable_i,
  input wire logic wait_n_i,
  input wire logic req_done_o,
  input wire logic read_write_o,
  input wire logic read_strobe_n_o,
  input wire logic low_byte_write_strobe_n_o,
  input wire logic high_byte_write_strobe_n_o,
  input wire logic addr_latch_en_o,
  input wire logic bus_grant_n_o,
  input wire logic strobe_oe_o,
  input wire logic [DW-1:0] mux_addr_data_lines_oe_o,
  input wire logic clk_out_o,
  input wire logic ext_internal_ack_o,
  input wire logic [NS-1:0] sel_pull_up_o,
  input wire logic [NS-1:0] sel_pull_down_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic wr_act = !low_byte_write_strobe_n_o || !high_byte_write_strobe_n_o;
  sequence s_hi; clk_out_o [*2]; endsequence
  sequence s_lo; !clk_out_o [*2]; endsequence
  property p_rw; wr_act |-> !read_write_o; endproperty
  a_rw: assert property (p_rw) else $error("direction high in write");
  property p_float; !bus_grant_n_o |-> !strobe_oe_o && mux_addr_data_lines_oe_o == '0; endproperty
  a_float: assert property (p_float) else $error("pins driven while granted");
  property p_first; $fell(bus_grant_n_o) |-> $past(strobe_oe_o) == 1'b0; endproperty
  a_first: assert property (p_first) else $error("grant before float");
  property p_ack; !ext_internal_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("outside access answered");
  property p_pull;
    !bus_grant_n_o && pull_enable_i |->
      sel_pull_up_o[SEL_PULLUP_IDX] && !sel_pull_down_o[SEL_PULLUP_IDX];
  endproperty
  a_pull: assert property (p_pull) else $error("third select pull wrong");
  property p_ale; $rose(addr_latch_en_o) |=> !addr_latch_en_o ##[3:300] req_done_o; endproperty
  a_ale: assert property (p_ale) else $error("latch pulse or cycle end wrong");
  property p_clk; $fell(clk_out_o) |-> s_lo ##1 s_hi; endproperty
  a_clk: assert property (p_clk) else $error("clock output not quarter rate");
  property p_wait; (!wait_n_i [*3]) ##0 !read_strobe_n_o |=> !read_strobe_n_o; endproperty
  a_wait: assert property (p_wait) else $error("strobe ended during wait");
endmodule
bind ebr_bus_if ebr_mon #(.DW(DW), .NS(NS)) u_mon (.clk_i, .rst_n_i, .pull_enable_i, .wait_n_i,
  .req_done_o, .read_write_o, .read_strobe_n_o, .low_byte_write_strobe_n_o,
  .high_byte_write_strobe_n_o, .addr_latch_en_o, .bus_grant_n_o, .strobe_oe_o,
  .mux_addr_data_lines_oe_o, .clk_out_o, .ext_internal_ack_o, .sel_pull_up_o, .sel_pull_down_o);
`default_nettype wire

// ### dv/ebr_far_mem.sv
/* External memory and bus master model on the far side.
   Assumes the bench resolves the shared data lines. */
`timescale 1ns/1ps
`default_nettype none
module ebr_far_mem
  import ebr_pkg::*;
(
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic dma_i,
  input wire logic addr_latch_en_o,
  input wire logic read_strobe_n_o,
  input wire logic low_byte_write_strobe_n_o,
  input wire logic high_byte_write_strobe_n_o,
  input wire logic [DATA_W-1:0] bus_i,
  output logic [DATA_W-1:0] drive_o,
  output logic wait_n_i,
  output logic bus_request_n_i
);
  // ****
  // Memory and handshakes
  // ****
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] junk_r = 16'h5a5a;
  logic [7:0] a_r = 8'h0;
  logic [2:0] w_r = 3'h0;
  initial foreach (mem[i]) mem[i] = 16'h0;
  assign bus_request_n_i = !dma_i;
  assign wait_n_i = (w_r == 3'h0);
  // Released lines show a changing pattern, not the last value
  assign drive_o = !read_strobe_n_o ? mem[a_r] : junk_r;
  always @(posedge clk_i) begin
    junk_r <= ~junk_r;
    if (addr_latch_en_o) a_r <= bus_i[8:1];
    if (!low_byte_write_strobe_n_o) mem[a_r][7:0] <= bus_i[7:0];
    if (!high_byte_write_strobe_n_o) mem[a_r][15:8] <= bus_i[15:8];
    // Wait raised at the latch pulse so the synced pin lands before strobe end
    if (addr_latch_en_o && slow_i) w_r <= 3'h5;
    else if (w_r != 3'h0) w_r <= w_r - 3'h1;
  end
endmodule
`default_nettype wire

// ### dv/external_bus_release_interface_test.sv
/* Self-checking bench for the bus interface with far-side model.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
`default_nettype none
module external_bus_release_interface_test;
  import ebr_pkg::*;
  logic clk_i = 0, rst_n_i = 0, req_i = 0, req_write_i = 0, req_dummy_i = 0, slow = 0, dma = 0;
  logic bus_enable_i = 0, upper_mode_i = 0, port2_mode_i = 0, pull_enable_i = 1;
  logic ext_internal_access_i = 0;
  logic [1:0] req_lanes_i = 0;
  logic [2:0] dram_mode_i = 0, sel_enable_i = 0;
  logic [23:0] req_addr_i = 0;
  logic [71:0] sel_base_i = {24'h020000, 24'h010000, 24'h000000}, sel_mask_i = {3{24'hff0000}};
  logic [15:0] req_wdata_i = 0, port_out_i = 0, port_oe_i = 0, drive, mux_addr_data_lines_i;
  logic [15:0] req_rdata_o, mux_addr_data_lines_o, mux_addr_data_lines_oe_o, shadow [256];
  logic [7:0] address_lines_o;
  logic [2:0] area_select_n_o, sel_pull_up_o, sel_pull_down_o;
  logic req_done_o, ext_internal_ack_o, address_lines_oe_o, read_strobe_n_o, read_write_o;
  logic low_byte_write_strobe_n_o, high_byte_write_strobe_n_o, row_strobe_n_o, strobe_oe_o;
  logic addr_latch_en_o, wait_n_i, bus_request_n_i, bus_grant_n_o, clk_out_o, bus_pull_en_o;
  int error_cnt = 0, total_checks = 0;
  assign mux_addr_data_lines_i = (mux_addr_data_lines_o & mux_addr_data_lines_oe_o)
    | (drive & ~mux_addr_data_lines_oe_o);
  ebr_bus_if DUT (.clk_i, .rst_n_i, .req_i, .req_write_i, .req_dummy_i, .req_lanes_i, .req_addr_i,
    .req_wdata_i, .req_done_o, .req_rdata_o, .bus_enable_i, .upper_mode_i, .port2_mode_i,
    .dram_mode_i, .sel_enable_i, .sel_base_i, .sel_mask_i, .pull_enable_i, .port_out_i,
    .port_oe_i, .ext_internal_access_i, .ext_internal_ack_o, .mux_addr_data_lines_i,
    .mux_addr_data_lines_o, .mux_addr_data_lines_oe_o, .address_lines_o, .address_lines_oe_o,
    .read_strobe_n_o, .low_byte_write_strobe_n_o, .high_byte_write_strobe_n_o, .read_write_o,
    .row_strobe_n_o, .area_select_n_o, .strobe_oe_o, .addr_latch_en_o, .wait_n_i,
    .bus_request_n_i, .bus_grant_n_o, .clk_out_o, .sel_pull_up_o, .sel_pull_down_o,
    .bus_pull_en_o);
  ebr_far_mem u_far (.clk_i, .slow_i(slow), .dma_i(dma), .addr_latch_en_o, .read_strobe_n_o,
    .low_byte_write_strobe_n_o, .high_byte_write_strobe_n_o, .bus_i(mux_addr_data_lines_i),
    .drive_o(drive), .wait_n_i, .bus_request_n_i);
  always #5 clk_i = ~clk_i;
  // ****
  // Checking tasks
  // ****
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [2:0] exp_sel(input logic [23:0] a);
    for (int i = 0; i < 3; i++)
      exp_sel[i] = !(sel_enable_i[i] && ((a ^ sel_base_i[i*24+:24]) & sel_mask_i[i*24+:24]) == 0);
  endfunction
  task automatic op(input logic wr, input logic dm, input logic [1:0] ln, input logic [23:0] a);
    int n;
    logic seen;
    seen = 0;
    {req_write_i, req_dummy_i, req_lanes_i, req_addr_i, req_wdata_i} = {wr, dm, ln, a, 16'($urandom)};
    req_i = 1;
    for (n = 0; n < 400 && req_done_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
      if (addr_latch_en_o === 1'b1) chk(address_lines_o, port2_mode_i ? a[23:16] : a[7:0]);
      if (!seen && !dm && (read_strobe_n_o & low_byte_write_strobe_n_o
          & high_byte_write_strobe_n_o) === 1'b0) begin
        seen = 1;
        chk(area_select_n_o, exp_sel(a));
        chk(row_strobe_n_o, &(exp_sel(a) | ~dram_mode_i));
        chk(read_write_o, !wr);
        chk(read_strobe_n_o, wr);
        chk(low_byte_write_strobe_n_o, !(wr && ln[0]));
        chk(high_byte_write_strobe_n_o, !(wr && ln[1]));
      end
    end
    req_i = 0;
    chk(n < 400, 1'b1);
    if (!wr && !dm) chk(req_rdata_o, shadow[a[8:1]]);
    if (wr && ln[0]) shadow[a[8:1]][7:0] = req_wdata_i[7:0];
    if (wr && ln[1]) shadow[a[8:1]][15:8] = req_wdata_i[15:8];
    @(posedge clk_i);
    #1;
  endtask
  task automatic release_bus;
    int n;
    dma = 1;
    for (n = 0; n < 200 && bus_grant_n_o !== 1'b0; n++) @(posedge clk_i);
    #1;
    chk({strobe_oe_o, mux_addr_data_lines_oe_o}, 17'h0);
    chk(sel_pull_up_o[SEL_PULLUP_IDX], pull_enable_i);
    chk({sel_pull_down_o, bus_pull_en_o}, {3'h0, pull_enable_i});
    ext_internal_access_i = 1;
    repeat (3) @(posedge clk_i);
    #1;
    chk(ext_internal_ack_o, 1'b0);
    {ext_internal_access_i, dma} = 2'b00;
    for (n = 0; n < 20 && bus_grant_n_o !== 1'b1; n++) @(posedge clk_i);
    #1;
    chk(bus_grant_n_o, 1'b1);
  endtask
  initial begin
    #300us;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    logic [23:0] a;
    void'($urandom(32'h570a));
    foreach (shadow[i]) shadow[i] = 16'h0;
    {port_out_i, port_oe_i} = $urandom;
    repeat (3) @(posedge clk_i);
    #1;
    chk({clk_out_o, bus_grant_n_o, mux_addr_data_lines_oe_o}, {2'b11, 16'h0});
    rst_n_i = 1;
    repeat (3) @(posedge clk_i);
    #1;
    chk(mux_addr_data_lines_oe_o, port_oe_i);
    chk(mux_addr_data_lines_o & port_oe_i, port_out_i & port_oe_i);
    bus_enable_i = 1;
    a = 24'h010046;
    slow = 1;
    op(1, 0, 2'b11, a);
    op(0, 0, 2'b00, a);
    op(0, 1, 2'b00, a);
    for (int k = 0; k < 60; k++) begin
      {pull_enable_i, dram_mode_i, sel_enable_i, port2_mode_i, slow} = 9'($urandom);
      if ($urandom % 8 == 0) release_bus();
      a = {6'h0, 2'($urandom), 16'($urandom)};
      op(1, 0, 2'($urandom % 3 + 1), a);
      op(0, 0, 2'b00, a);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
